// >>> dmc_pkg.sv
// Purpose: Shared constants for the DDS mode control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are word indices; the byte address is four times one
package dmc_pkg;
   // ************************************
   // Register map
   // ************************************
   localparam logic [7:0] OFS_TONE1_LO  = 8'h04;
   localparam logic [7:0] OFS_TONE1_HI  = 8'h08;
   localparam logic [7:0] OFS_TONE2_LO  = 8'h0C;
   localparam logic [7:0] OFS_TONE2_HI  = 8'h10;
   localparam logic [7:0] OFS_PHASE1    = 8'h14;
   localparam logic [7:0] OFS_PHASE2    = 8'h18;
   localparam logic [7:0] OFS_AMPL      = 8'h1C;
   localparam logic [7:0] OFS_CLKCTL    = 8'h1E;
   localparam logic [7:0] OFS_MODECTL   = 8'h1F;
   localparam logic [7:0] OFS_STATUS    = 8'h20;
   localparam logic [7:0] OFS_SYNC_PORT = 8'h24;
   // ************************************
   // Fields and reset values
   // ************************************
   localparam int MODE_LSB   = 0;
   localparam int BYPASS_BIT = 0;
   localparam int HOLD_BIT   = 3;
   localparam logic [47:0] TONE_RST  = 48'h0000_0000_0000;
   localparam logic [13:0] PHASE_RST = 14'h0000;
   localparam logic [11:0] AMPL_RST  = 12'h000;
   localparam logic [11:0] DAC_MID   = 12'h800;
   localparam int NUM_PROG_REGS = 28;
   typedef enum logic [2:0] {
      MODE_SINGLE = 3'h0,
      MODE_FSK    = 3'h1,
      MODE_RFSK   = 3'h2,
      MODE_CHIRP  = 3'h3,
      MODE_BPSK   = 3'h4
   } dmc_mode_e;
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRESP,
      BUS_RRESP
   } dmc_bus_e;
endpackage

// >>> dmc_mode_control.sv
// Purpose: Mode decode, reset defaults and clock/port selection of a DDS
// Assumes: aclk is the system clock; inputs synchronous to aclk
// Notes:   Registers live behind an AXI4-Lite slave
//
// Functional notes
// - Mode from three-bit field at 0x1F
// - Decode 000..100 to five modes
// - Master init forces single-tone mode
// - Single tone feeds first tone word
// - Defaults give zero frequency, zero phase
// - Amplitude zero; DACs at midscale
// - Master init reloads all register defaults
// - Select pin: low serial, high parallel
// - Differential enable picks differential reference
// - Bypass bit at 0x1E skips multiplier
// - Keying pin ignored in single tone
// - Second phase register used only in BPSK mode
// - Second word only in FSK modes
// - Frequency equals word times clock over 2^48
// - Twenty-eight programmable registers exist
// - Keying pin selects word, phase or hold
// - Accumulator and tuning words 48 bits
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module dmc_mode_control
#(
   parameter int ACC_W = 48,
   parameter int PH_W  = 14
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              master_init,
   input  wire logic              parallel_select,
   input  wire logic              differential_reference_clock_in_on,
   input  wire logic              keying_hold_pin,
   input  wire logic [31:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [31:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [ACC_W-1:0]       tuning_word,
   output logic [PH_W-1:0]        phase_word,
   output logic                   chirp_hold,
   output logic [11:0]            dac_i_code,
   output logic [11:0]            dac_q_code,
   output logic                   use_differential_ref,
   output logic                   multiplier_bypass,
   output logic                   serial_port_active
);
   if (ACC_W != 48 || PH_W != 14)
   begin : g_width_check
      $error("dmc_mode_control: widths must be 48 and 14");
   end

   // ************************************
   // Helpers
   // ************************************
   // Unknown codes fall back to single tone so output stays defined
   function automatic dmc_pkg::dmc_mode_e decode_mode(input logic [2:0] f);
      dmc_pkg::dmc_mode_e m;
      m = dmc_pkg::MODE_SINGLE;
      if (f <= 3'h4)
         m = dmc_pkg::dmc_mode_e'(f);
      return m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
         begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ************************************
   // Register file and bus
   // ************************************
   logic [ACC_W-1:0]  tone1_r, tone1_nxt, tone2_r, tone2_nxt;
   logic [PH_W-1:0]   ph1_r, ph1_nxt, ph2_r, ph2_nxt;
   logic [11:0]       ampl_r, ampl_nxt;
   logic [2:0]        mode_r, mode_nxt;
   logic              bypass_r, bypass_nxt;
   dmc_pkg::dmc_bus_e bst_r, bst_nxt;
   logic              awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
   logic [7:0]        awa_r, awa_nxt, rd_idx;
   logic [31:0]       wd_r, wd_nxt;
   logic [3:0]        ws_r, ws_nxt;
   logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              bv_r, bv_nxt, rv_r, rv_nxt;
   logic [31:0]       cur;
   logic              hit;
   dmc_pkg::dmc_mode_e mode_q;

   assign mode_q = decode_mode(mode_r);
   assign rd_idx = s_axi_araddr[9:2];

   always_comb
   begin
      tone1_nxt = tone1_r;
      tone2_nxt = tone2_r;
      ph1_nxt = ph1_r;
      ph2_nxt = ph2_r;
      ampl_nxt = ampl_r;
      mode_nxt = mode_r;
      bypass_nxt = bypass_r;
      bst_nxt = bst_r;
      awr_nxt = 1'b0;
      wr_nxt = 1'b0;
      arr_nxt = 1'b0;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      bresp_nxt = bresp_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      bv_nxt = bv_r;
      rv_nxt = rv_r;
      cur = 32'h0000_0000;
      hit = 1'b1;
      if (s_axi_awvalid && awr_r)
      begin
         awa_nxt = s_axi_awaddr[9:2];
         aw_have_nxt = 1'b1;
      end
      if (s_axi_wvalid && wr_r)
      begin
         wd_nxt = s_axi_wdata;
         ws_nxt = s_axi_wstrb;
         w_have_nxt = 1'b1;
      end
      case (bst_r)
         dmc_pkg::BUS_IDLE:
         begin
            if (aw_have_r && w_have_r)
            begin
               aw_have_nxt = 1'b0;
               w_have_nxt = 1'b0;
               if (awa_r == dmc_pkg::OFS_TONE1_LO)
                  tone1_nxt[31:0] = merge(tone1_r[31:0], wd_r, ws_r);
               else if (awa_r == dmc_pkg::OFS_TONE1_HI)
                  tone1_nxt[47:32] = 16'(merge({16'h0000, tone1_r[47:32]}, wd_r, ws_r));
               else if (awa_r == dmc_pkg::OFS_TONE2_LO)
                  tone2_nxt[31:0] = merge(tone2_r[31:0], wd_r, ws_r);
               else if (awa_r == dmc_pkg::OFS_TONE2_HI)
                  tone2_nxt[47:32] = 16'(merge({16'h0000, tone2_r[47:32]}, wd_r, ws_r));
               else if (awa_r == dmc_pkg::OFS_PHASE1)
                  ph1_nxt = 14'(merge({18'h00000, ph1_r}, wd_r, ws_r));
               else if (awa_r == dmc_pkg::OFS_PHASE2)
                  ph2_nxt = 14'(merge({18'h00000, ph2_r}, wd_r, ws_r));
               else if (awa_r == dmc_pkg::OFS_AMPL)
                  ampl_nxt = 12'(merge({20'h00000, ampl_r}, wd_r, ws_r));
               else if (awa_r == dmc_pkg::OFS_CLKCTL && ws_r[0])
                  bypass_nxt = wd_r[dmc_pkg::BYPASS_BIT];
               else if (awa_r == dmc_pkg::OFS_MODECTL && ws_r[0])
                  mode_nxt = wd_r[dmc_pkg::MODE_LSB +: 3];
               else
                  hit = 1'b0;
               bresp_nxt = hit ? 2'h0 : 2'h2;
               bv_nxt = 1'b1;
               bst_nxt = dmc_pkg::BUS_WRESP;
            end
            else if (s_axi_arvalid && arr_r)
            begin
               // Word index decode; every register takes one aligned word
               if (rd_idx == dmc_pkg::OFS_TONE1_LO)
                  cur = tone1_r[31:0];
               else if (rd_idx == dmc_pkg::OFS_TONE1_HI)
                  cur = {16'h0000, tone1_r[47:32]};
               else if (rd_idx == dmc_pkg::OFS_TONE2_LO)
                  cur = tone2_r[31:0];
               else if (rd_idx == dmc_pkg::OFS_TONE2_HI)
                  cur = {16'h0000, tone2_r[47:32]};
               else if (rd_idx == dmc_pkg::OFS_PHASE1)
                  cur = {18'h00000, ph1_r};
               else if (rd_idx == dmc_pkg::OFS_PHASE2)
                  cur = {18'h00000, ph2_r};
               else if (rd_idx == dmc_pkg::OFS_AMPL)
                  cur = {20'h00000, ampl_r};
               else if (rd_idx == dmc_pkg::OFS_CLKCTL)
                  cur = {31'h0000_0000, bypass_r};
               else if (rd_idx == dmc_pkg::OFS_MODECTL)
                  cur = {29'h0000_0000, mode_r};
               else if (rd_idx == dmc_pkg::OFS_STATUS)
                  cur = {28'h000_0000, chirp_hold, mode_q};
               else if (rd_idx == dmc_pkg::OFS_SYNC_PORT)
                  cur = {30'h0000_0000, differential_reference_clock_in_on, parallel_select};
               else
                  hit = 1'b0;
               rdata_nxt = cur;
               rresp_nxt = hit ? 2'h0 : 2'h2;
               rv_nxt = 1'b1;
               bst_nxt = dmc_pkg::BUS_RRESP;
            end
            else
            begin
               awr_nxt = !aw_have_nxt;
               wr_nxt = !w_have_nxt;
               arr_nxt = !(aw_have_nxt && w_have_nxt);
            end
         end
         dmc_pkg::BUS_WRESP:
         begin
            if (s_axi_bready)
            begin
               bv_nxt = 1'b0;
               bst_nxt = dmc_pkg::BUS_IDLE;
            end
         end
         default:
         begin
            if (s_axi_rready)
            begin
               rv_nxt = 1'b0;
               bst_nxt = dmc_pkg::BUS_IDLE;
            end
         end
      endcase
      if (master_init)
      begin
         tone1_nxt = dmc_pkg::TONE_RST;
         tone2_nxt = dmc_pkg::TONE_RST;
         ph1_nxt = dmc_pkg::PHASE_RST;
         ph2_nxt = dmc_pkg::PHASE_RST;
         ampl_nxt = dmc_pkg::AMPL_RST;
         mode_nxt = dmc_pkg::MODE_SINGLE;
         bypass_nxt = 1'b0;
         bst_nxt = dmc_pkg::BUS_IDLE;
         awr_nxt = 1'b0;
         wr_nxt = 1'b0;
         arr_nxt = 1'b0;
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bv_nxt = 1'b0;
         rv_nxt = 1'b0;
      end
   end

   // ************************************
   // Datapath selection
   // ************************************
   logic [ACC_W-1:0] tw_nxt;
   logic [PH_W-1:0]  pw_nxt;
   logic             hold_nxt;
   logic [11:0]      dac_nxt;

   always_comb
   begin
      tw_nxt = tone1_r;
      pw_nxt = ph1_r;
      hold_nxt = 1'b0;
      case (mode_q)
         dmc_pkg::MODE_FSK, dmc_pkg::MODE_RFSK:
            tw_nxt = keying_hold_pin ? tone2_r : tone1_r;
         dmc_pkg::MODE_CHIRP:
            hold_nxt = keying_hold_pin;
         dmc_pkg::MODE_BPSK:
            pw_nxt = keying_hold_pin ? ph2_r : ph1_r;
         default:
            tw_nxt = tone1_r;
      endcase
      // Half the amplitude is ORed onto midscale; zero amplitude gives midscale
      dac_nxt = (ampl_r == dmc_pkg::AMPL_RST) ? dmc_pkg::DAC_MID : (dmc_pkg::DAC_MID | {1'b0, ampl_r[11:1]});
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tone1_r <= dmc_pkg::TONE_RST;
         tone2_r <= dmc_pkg::TONE_RST;
         ph1_r <= dmc_pkg::PHASE_RST;
         ph2_r <= dmc_pkg::PHASE_RST;
         ampl_r <= dmc_pkg::AMPL_RST;
         mode_r <= dmc_pkg::MODE_SINGLE;
         bypass_r <= 1'b0;
         bst_r <= dmc_pkg::BUS_IDLE;
         awr_r <= 1'b0;
         wr_r <= 1'b0;
         arr_r <= 1'b0;
         awa_r <= 8'h00;
         wd_r <= 32'h0000_0000;
         ws_r <= 4'h0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         bresp_r <= 2'h0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0000_0000;
         bv_r <= 1'b0;
         rv_r <= 1'b0;
         tuning_word <= dmc_pkg::TONE_RST;
         phase_word <= dmc_pkg::PHASE_RST;
         chirp_hold <= 1'b0;
         dac_i_code <= dmc_pkg::DAC_MID;
         dac_q_code <= dmc_pkg::DAC_MID;
         use_differential_ref <= 1'b0;
         multiplier_bypass <= 1'b0;
         serial_port_active <= 1'b1;
      end
      else
      begin
         tone1_r <= tone1_nxt;
         tone2_r <= tone2_nxt;
         ph1_r <= ph1_nxt;
         ph2_r <= ph2_nxt;
         ampl_r <= ampl_nxt;
         mode_r <= mode_nxt;
         bypass_r <= bypass_nxt;
         bst_r <= bst_nxt;
         awr_r <= awr_nxt;
         wr_r <= wr_nxt;
         arr_r <= arr_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         bv_r <= bv_nxt;
         rv_r <= rv_nxt;
         tuning_word <= tw_nxt;
         phase_word <= pw_nxt;
         chirp_hold <= hold_nxt;
         dac_i_code <= dac_nxt;
         dac_q_code <= dac_nxt;
         use_differential_ref <= differential_reference_clock_in_on;
         multiplier_bypass <= bypass_r;
         serial_port_active <= !parallel_select;
      end
   end

   assign s_axi_awready = awr_r;
   assign s_axi_wready = wr_r;
   assign s_axi_arready = arr_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
endmodule // dmc_mode_control
`default_nettype wire

// >>> dmc_mode_control_props.sv
// Purpose: Port-level checks for the mode control block
// Assumes: One clock aclk, synchronous active-low aresetn
// Notes:   Bound to the design from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module dmc_mode_control_props
#(
   parameter int ACC_W = 48,
   parameter int PH_W  = 14
)
(
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic             master_init,
   input wire logic             parallel_select,
   input wire logic             differential_reference_clock_in_on,
   input wire logic             keying_hold_pin,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [ACC_W-1:0] tuning_word,
   input wire logic [PH_W-1:0]  phase_word,
   input wire logic             chirp_hold,
   input wire logic [11:0]      dac_i_code,
   input wire logic [11:0]      dac_q_code,
   input wire logic             use_differential_ref,
   input wire logic             serial_port_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************
   // Checks
   // ****************************************
   init_zero_a: assert property (master_init |-> ##2 tuning_word == '0 && phase_word == '0)
      else $error("words not cleared by init");
   init_mid_a: assert property (master_init |-> ##2 dac_i_code == dmc_pkg::DAC_MID)
      else $error("dac not midscale after init");
   dac_pair_a: assert property (dac_i_code == dac_q_code && dac_i_code[11])
      else $error("dac codes differ");
   port_sel_a: assert property ($past(aresetn) |-> serial_port_active == !$past(parallel_select))
      else $error("port select wrong");
   ref_sel_a: assert property ($past(aresetn) |-> use_differential_ref == $past(differential_reference_clock_in_on))
      else $error("reference select wrong");
   hold_cause_a: assert property ($rose(chirp_hold) |-> $past(keying_hold_pin))
      else $error("hold without pin");
   // Init aborts bus state, so answers are only held outside it
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready && !master_init |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready && !master_init |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   read_ans_a: assert property (s_axi_arvalid && s_axi_arready && !master_init |=> s_axi_rvalid)
      else $error("read answer late");
   write_ans_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !master_init)
      ##1 !master_init |=> s_axi_bvalid)
      else $error("write answer late");
endmodule // dmc_mode_control_props
`default_nettype wire

// >>> dmc_host.sv
// Purpose: Host controller model on the register bus
// Assumes: Tasks are entered just after a rising aclk edge
// Notes:   Released address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module dmc_host
(
   input  wire logic        aclk,
   output logic             master_init,
   output logic [31:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [31:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   logic slow = 1'b0;
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, master_init} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
   end
   // ****************************************
   // Bus cycles
   // ****************************************
   task automatic init();
      master_init <= 1'b1;
      repeat (2) @(posedge aclk);
      master_init <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      s_axi_awaddr <= {22'h0, a, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      while (!(ad && dd))
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            dd = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
      end
      do
      begin
         @(posedge aclk);
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= {22'h0, a, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~s_axi_araddr;
      do
      begin
         @(posedge aclk);
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
endmodule // dmc_host
`default_nettype wire

// >>> test_dmc_mode_control.sv
// Purpose: Self-checking bench for the mode control block
// Assumes: Host model drives the register bus and master init
// Notes:   Outputs are looked at a few edges after each change
`timescale 1ns/100ps
`default_nettype none
module test_dmc_mode_control;
   localparam logic [47:0] T1 = 48'h1234_5678_9ABC;
   localparam logic [47:0] T2 = 48'h0F0E_0D0C_0B0A;
   localparam logic [13:0] P1 = 14'h1555;
   localparam logic [13:0] P2 = 14'h2AAA;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        parallel_select = 1'b0;
   logic        differential_reference_clock_in_on = 1'b0;
   logic        keying_hold_pin = 1'b0;
   logic        master_init, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [47:0] tuning_word;
   logic [13:0] phase_word;
   logic [11:0] dac_i_code, dac_q_code;
   logic        chirp_hold, use_differential_ref, multiplier_bypass, serial_port_active;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   dmc_mode_control dut (.*);
   dmc_host host (.*);
   initial forever #5 aclk = ~aclk;
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_modes();
      logic [2:0] m;
      host.wr(dmc_pkg::OFS_TONE1_LO, T1[31:0], rsp);
      host.wr(dmc_pkg::OFS_TONE1_HI, {16'h0, T1[47:32]}, rsp);
      host.wr(dmc_pkg::OFS_TONE2_LO, T2[31:0], rsp);
      host.wr(dmc_pkg::OFS_TONE2_HI, {16'h0, T2[47:32]}, rsp);
      host.wr(dmc_pkg::OFS_PHASE1, {18'h0, P1}, rsp);
      host.wr(dmc_pkg::OFS_PHASE2, {18'h0, P2}, rsp);
      for (int c = 0; c < 8; c++)
      begin
         // Codes above four fall back to single tone
         m = (c > 4) ? 3'h0 : 3'(c);
         host.wr(dmc_pkg::OFS_MODECTL, 32'(c), rsp);
         for (int k = 0; k < 2; k++)
         begin
            keying_hold_pin <= k[0];
            repeat (3) @(posedge aclk);
            chk(tuning_word, (k[0] && (m == 3'h1 || m == 3'h2)) ? T2 : T1, "tone word");
            chk(phase_word, (k[0] && m == 3'h4) ? P2 : P1, "phase word");
            chk(chirp_hold, k[0] && m == 3'h3, "hold");
            host.rd(dmc_pkg::OFS_STATUS, rd_d, rsp);
            chk(rd_d[3:0], {k[0] && m == 3'h3, m}, "status");
         end
      end
      keying_hold_pin <= 1'b0;
   endtask
   task automatic test_pins();
      for (int j = 0; j < 4; j++)
      begin
         parallel_select <= j[0];
         differential_reference_clock_in_on <= j[1];
         repeat (2) @(posedge aclk);
         chk(serial_port_active, !j[0], "port select");
         chk(use_differential_ref, j[1], "ref select");
         host.rd(dmc_pkg::OFS_SYNC_PORT, rd_d, rsp);
         chk(rd_d[1:0], j[1:0], "pin status");
      end
      for (int j = 1; j >= 0; j--)
      begin
         host.wr(dmc_pkg::OFS_CLKCTL, 32'(j), rsp);
         repeat (4) @(posedge aclk);
         chk(multiplier_bypass, j[0], "bypass");
      end
   endtask
   task automatic test_unmapped();
      host.slow = 1'b1;
      host.wr(8'h40, 32'hFFFF_FFFF, rsp);
      chk(rsp, 2'h2, "write slverr");
      host.rd(8'h40, rd_d, rsp);
      chk({rsp, rd_d}, {2'h2, 32'h0}, "read slverr");
      host.rd(dmc_pkg::OFS_TONE1_LO, rd_d, rsp);
      chk({rsp, rd_d}, {2'h0, T1[31:0]}, "slow read");
      host.slow = 1'b0;
   endtask
   task automatic test_init();
      host.wr(dmc_pkg::OFS_MODECTL, 32'h1, rsp);
      host.wr(dmc_pkg::OFS_AMPL, 32'hFF, rsp);
      repeat (3) @(posedge aclk);
      chk(dac_i_code, 12'h87F, "amplitude");
      host.init();
      repeat (2) @(posedge aclk);
      chk({tuning_word, phase_word}, '0, "init words");
      chk({dac_i_code, dac_q_code}, {dmc_pkg::DAC_MID, dmc_pkg::DAC_MID}, "midscale");
      host.rd(dmc_pkg::OFS_STATUS, rd_d, rsp);
      chk(rd_d[3:0], 4'h0, "mode after init");
      host.rd(dmc_pkg::OFS_TONE1_HI, rd_d, rsp);
      chk(rd_d, 32'h0, "tone word default");
   endtask
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         $display("ERROR %0t timeout", $time);
         final_report();
      end
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      host.init();
      repeat (2) @(posedge aclk);
      chk({dac_i_code, tuning_word}, {dmc_pkg::DAC_MID, 48'h0}, "defaults");
      test_modes();
      test_pins();
      test_unmapped();
      test_init();
      final_report();
   end
endmodule // test_dmc_mode_control
bind dmc_mode_control dmc_mode_control_props #(.ACC_W(ACC_W), .PH_W(PH_W)) chk_i (.*);
`default_nettype wire
